// ### logic/bst_pkg.sv
`default_nettype none
package bst_pkg;
	localparam int IR_WIDTH   = 3;
	localparam int ID_WIDTH   = 32;
	localparam int BSR_LENGTH = 109;
	localparam int OE_CELL    = 47;
	localparam int RESET_HOLD = 5;

	// Instruction encodings
	localparam logic [2:0] INS_EXTEST   = 3'h0;
	localparam logic [2:0] INS_IDCODE   = 3'h1;
	localparam logic [2:0] INS_SAMPLEZ  = 3'h2;
	localparam logic [2:0] INS_RSVD3    = 3'h3;
	localparam logic [2:0] INS_SAMPLE   = 3'h4;
	localparam logic [2:0] INS_RSVD5    = 3'h5;
	localparam logic [2:0] INS_RSVD6    = 3'h6;
	localparam logic [2:0] INS_BYPASS   = 3'h7;

	localparam logic [1:0] IR_CAPTURE   = 2'h1;

	// Arbitrary identification value
	localparam logic [31:0] ID_CODE_DEFAULT = 32'h1A5C_0F3B;

	typedef enum logic [15:0] {
		ST_RESET   = 16'h0001,
		ST_IDLE    = 16'h0002,
		ST_SELDR   = 16'h0004,
		ST_CAPDR   = 16'h0008,
		ST_SHDR    = 16'h0010,
		ST_EX1DR   = 16'h0020,
		ST_PAUSEDR = 16'h0040,
		ST_EX2DR   = 16'h0080,
		ST_UPDDR   = 16'h0100,
		ST_SELIR   = 16'h0200,
		ST_CAPIR   = 16'h0400,
		ST_SHIR    = 16'h0800,
		ST_EX1IR   = 16'h1000,
		ST_PAUSEIR = 16'h2000,
		ST_EX2IR   = 16'h4000,
		ST_UPDIR   = 16'h8000
	} bst_state_e;
endpackage
`default_nettype wire

// ### logic/bst_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bst_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_dout;

	always_comb begin
		next_stage1 = din;
		next_dout   = stage1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= next_stage1;
			dout   <= next_dout;
		end
	end
endmodule // bst_sync
`default_nettype wire

// ### logic/bst_tap.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap #(
	parameter int          CHAIN_LEN = bst_pkg::BSR_LENGTH,
	parameter logic [31:0] ID_CODE   = bst_pkg::ID_CODE_DEFAULT
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tmsDriven,
	input  wire logic                 tdi,
	input  wire logic                 tdiDriven,
	input  wire logic [CHAIN_LEN-1:0] pinRing,
	output logic                      tdo,
	output logic                      tdoOe,
	output logic      [CHAIN_LEN-1:0] pinDrive,
	output logic                      pinOverride,
	output logic                      outBusOe,
	output logic                      outBusFloat
);
	// Elaboration-time refusal of a chain that cannot hold the bus enable cell
	if (CHAIN_LEN <= bst_pkg::OE_CELL) begin : g_bad_chain
		$error("Chain too short for output enable cell");
	end

	logic [2:0] syncIn;
	logic       tckS;
	logic       tmsS;
	logic       tdiS;

	// Undriven pins read as pulled high
	bst_sync #(.WIDTH(3)) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  ({tck, tms | ~tmsDriven, tdi | ~tdiDriven}),
		.dout (syncIn)
	);
	assign tckS = syncIn[2];
	assign tmsS = syncIn[1];
	assign tdiS = syncIn[0];

	bst_pkg::bst_state_e state;
	bst_pkg::bst_state_e next_state;
	logic                      tckPrev;
	logic [2:0]                irShift;
	logic [2:0]                irActive;
	logic                      bypassReg;
	logic [31:0]               idReg;
	logic [CHAIN_LEN-1:0]      bsrShift;
	logic [CHAIN_LEN-1:0]      bsrLatch;
	logic                      floatHold;
	logic [2:0]                next_irShift;
	logic [2:0]                next_irActive;
	logic                      next_bypassReg;
	logic [31:0]               next_idReg;
	logic [CHAIN_LEN-1:0]      next_bsrShift;
	logic [CHAIN_LEN-1:0]      next_bsrLatch;
	logic                      next_floatHold;
	logic                      next_tdo;
	logic                      next_tdoOe;
	logic                      next_tckPrev;
	logic                      rise;
	logic                      fall;
	logic                      serialBit;

	assign rise = tckS & ~tckPrev;
	assign fall = ~tckS & tckPrev;

	function automatic bit usesChain(input logic [2:0] ins);
		return ins == bst_pkg::INS_EXTEST || ins == bst_pkg::INS_SAMPLE || ins == bst_pkg::INS_SAMPLEZ;
	endfunction

	// Controller transitions
	always_comb begin
		next_state = state;
		if (rise) begin
			unique case (state)
				bst_pkg::ST_RESET:   next_state = tmsS ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
				bst_pkg::ST_IDLE:    next_state = tmsS ? bst_pkg::ST_SELDR : bst_pkg::ST_IDLE;
				bst_pkg::ST_SELDR:   next_state = tmsS ? bst_pkg::ST_SELIR : bst_pkg::ST_CAPDR;
				bst_pkg::ST_CAPDR:   next_state = tmsS ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
				bst_pkg::ST_SHDR:    next_state = tmsS ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
				bst_pkg::ST_EX1DR:   next_state = tmsS ? bst_pkg::ST_UPDDR : bst_pkg::ST_PAUSEDR;
				bst_pkg::ST_PAUSEDR: next_state = tmsS ? bst_pkg::ST_EX2DR : bst_pkg::ST_PAUSEDR;
				bst_pkg::ST_EX2DR:   next_state = tmsS ? bst_pkg::ST_UPDDR : bst_pkg::ST_SHDR;
				bst_pkg::ST_UPDDR:   next_state = tmsS ? bst_pkg::ST_SELDR : bst_pkg::ST_IDLE;
				// Five high samples from any state end here
				bst_pkg::ST_SELIR:   next_state = tmsS ? bst_pkg::ST_RESET : bst_pkg::ST_CAPIR;
				bst_pkg::ST_CAPIR:   next_state = tmsS ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
				bst_pkg::ST_SHIR:    next_state = tmsS ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
				bst_pkg::ST_EX1IR:   next_state = tmsS ? bst_pkg::ST_UPDIR : bst_pkg::ST_PAUSEIR;
				bst_pkg::ST_PAUSEIR: next_state = tmsS ? bst_pkg::ST_EX2IR : bst_pkg::ST_PAUSEIR;
				bst_pkg::ST_EX2IR:   next_state = tmsS ? bst_pkg::ST_UPDIR : bst_pkg::ST_SHIR;
				bst_pkg::ST_UPDIR:   next_state = tmsS ? bst_pkg::ST_SELDR : bst_pkg::ST_IDLE;
				default:             next_state = bst_pkg::ST_RESET;
			endcase
		end
	end

	// Serial registers
	always_comb begin
		next_irShift   = irShift;
		next_irActive  = irActive;
		next_bypassReg = bypassReg;
		next_idReg     = idReg;
		next_bsrShift  = bsrShift;
		next_bsrLatch  = bsrLatch;
		next_floatHold = floatHold;
		next_tckPrev   = tckS;
		if (rise) begin
			unique case (state)
				bst_pkg::ST_RESET: begin
					next_irActive = bst_pkg::INS_IDCODE;
					next_bsrLatch[bst_pkg::OE_CELL] = 1'b1;
					next_floatHold = 1'b0;
				end
				bst_pkg::ST_CAPIR: next_irShift = {irShift[2], bst_pkg::IR_CAPTURE};
				bst_pkg::ST_SHIR:  next_irShift = {tdiS, irShift[2:1]};
				bst_pkg::ST_UPDIR: begin
					next_irActive  = irShift;
					next_floatHold = irShift == bst_pkg::INS_SAMPLEZ;
					if (!usesChain(irShift) && irShift != bst_pkg::INS_IDCODE)
						next_bypassReg = 1'b0;
				end
				bst_pkg::ST_CAPDR: begin
					if (usesChain(irActive))
						next_bsrShift = pinRing;
					else if (irActive == bst_pkg::INS_IDCODE)
						next_idReg = ID_CODE;
					else
						next_bypassReg = 1'b0;
				end
				bst_pkg::ST_SHDR: begin
					if (usesChain(irActive))
						next_bsrShift = {tdiS, bsrShift[CHAIN_LEN-1:1]};
					else if (irActive == bst_pkg::INS_IDCODE)
						next_idReg = {tdiS, idReg[31:1]};
					else
						next_bypassReg = tdiS;
				end
				bst_pkg::ST_UPDDR: begin
					if (usesChain(irActive))
						next_bsrLatch = bsrShift;
				end
				default: begin
				end
			endcase
		end
	end

	// One register on the path at a time
	always_comb begin
		if (state == bst_pkg::ST_SHIR)
			serialBit = irShift[0];
		else if (usesChain(irActive))
			serialBit = bsrShift[0];
		else if (irActive == bst_pkg::INS_IDCODE)
			serialBit = idReg[0];
		else
			serialBit = bypassReg;
		next_tdo   = tdo;
		next_tdoOe = tdoOe;
		if (fall) begin
			next_tdo   = serialBit;
			next_tdoOe = state == bst_pkg::ST_SHDR || state == bst_pkg::ST_SHIR;
		end
	end

	// Pin side drive is derived only from test state, never from memory logic
	logic                 next_pinOverride;
	logic                 next_outBusOe;
	logic                 next_outBusFloat;
	logic [CHAIN_LEN-1:0] next_pinDrive;
	always_comb begin
		next_pinOverride = irActive == bst_pkg::INS_EXTEST;
		next_pinDrive    = bsrLatch;
		next_outBusOe    = next_pinOverride & bsrLatch[bst_pkg::OE_CELL];
		next_outBusFloat = floatHold | (next_pinOverride & ~bsrLatch[bst_pkg::OE_CELL]);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state       <= bst_pkg::ST_RESET;
			tckPrev     <= 1'b0;
			irShift     <= '0;
			irActive    <= bst_pkg::INS_IDCODE;
			bypassReg   <= 1'b0;
			idReg       <= '0;
			bsrShift    <= '0;
			bsrLatch    <= '0;
			bsrLatch[bst_pkg::OE_CELL] <= 1'b1;
			floatHold   <= 1'b0;
			tdo         <= 1'b0;
			tdoOe       <= 1'b0;
			pinDrive    <= '0;
			pinDrive[bst_pkg::OE_CELL] <= 1'b1;
			pinOverride <= 1'b0;
			outBusOe    <= 1'b0;
			outBusFloat <= 1'b0;
		end else begin
			state       <= next_state;
			tckPrev     <= next_tckPrev;
			irShift     <= next_irShift;
			irActive    <= next_irActive;
			bypassReg   <= next_bypassReg;
			idReg       <= next_idReg;
			bsrShift    <= next_bsrShift;
			bsrLatch    <= next_bsrLatch;
			floatHold   <= next_floatHold;
			tdo         <= next_tdo;
			tdoOe       <= next_tdoOe;
			pinDrive    <= next_pinDrive;
			pinOverride <= next_pinOverride;
			outBusOe    <= next_outBusOe;
			outBusFloat <= next_outBusFloat;
		end
	end
endmodule // bst_tap
`default_nettype wire

// ### verif/bst_tap_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap_checker #(
	parameter int CHAIN_LEN = 109
) (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic                 tck,
	input wire logic                 tms,
	input wire logic                 tmsDriven,
	input wire logic                 tdi,
	input wire logic                 tdiDriven,
	input wire logic [CHAIN_LEN-1:0] pinRing,
	input wire logic                 tdo,
	input wire logic                 tdoOe,
	input wire logic [CHAIN_LEN-1:0] pinDrive,
	input wire logic                 pinOverride,
	input wire logic                 outBusOe,
	input wire logic                 outBusFloat
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Test clock has not moved for six system clocks
	sequence sQuiet;
		$stable(tck) [*6];
	endsequence
	chk_reset_float: assert property ($fell(rst) |-> !tdoOe) else $error("tdo driven after reset");
	chk_oe_preset: assert property ($fell(rst) |-> pinDrive[47]) else $error("cell 47 not preset");
	chk_reset_ir: assert property ($fell(rst) |-> !pinOverride) else $error("override after reset");
	chk_tdo_fall: assert property ($changed(tdo) |-> !tck && !$past(tck, 3)) else $error("tdo off fall");
	chk_oe_fall: assert property ($changed(tdoOe) |-> !tck && !$past(tck, 3)) else $error("oe off fall");
	chk_quiet_tdo: assert property (sQuiet |-> $stable(tdo) && $stable(tdoOe)) else $error("tdo moved");
	chk_quiet_pins: assert property (sQuiet |-> $stable(pinDrive) && $stable(outBusOe)) else $error("pins moved");
	chk_bus_excl: assert property (!(outBusOe && outBusFloat)) else $error("bus both driven and floated");
	chk_oe_extest: assert property (outBusOe |-> pinOverride && pinDrive[47]) else $error("bus drive wrong");
endmodule // bst_tap_checker

bind bst_tap bst_tap_checker #(.CHAIN_LEN(CHAIN_LEN)) chk (.clk(clk), .rst(rst), .tck(tck), .tms(tms),
	.tmsDriven(tmsDriven), .tdi(tdi), .tdiDriven(tdiDriven), .pinRing(pinRing), .tdo(tdo), .tdoOe(tdoOe),
	.pinDrive(pinDrive), .pinOverride(pinOverride), .outBusOe(outBusOe), .outBusFloat(outBusFloat));
`default_nettype wire

// ### verif/bst_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
	input  wire logic clk,
	input  wire logic tdo,
	output logic      tck,
	output logic      tms,
	output logic      tmsDriven,
	output logic      tdi,
	output logic      tdiDriven
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tmsDriven = 1'b1;
		tdi = 1'b1;
		tdiDriven = 1'b1;
	end
	// One test clock of 40 system clocks; tdo read just before the rise
	task automatic step(input logic m, input logic d, output logic o);
		@(posedge clk);
		tms <= m;
		tdi <= d;
		repeat (10) @(posedge clk);
		o = tdo;
		tck <= 1'b1;
		repeat (20) @(posedge clk);
		tck <= 1'b0;
		repeat (9) @(posedge clk);
	endtask
	task automatic walk(input logic [7:0] s, input int n);
		logic o;
		for (int i = 0; i < n; i++) step(s[i], 1'b1, o);
	endtask
	task automatic reset5();
		walk(8'h1F, 5);
		walk(8'h00, 1);
	endtask
	// From idle: capture, shift n bits LSB first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
		logic o;
		dout = '0;
		walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		walk(8'h01, 2);
	endtask
endmodule // bst_ctl_model
`default_nettype wire

// ### verif/sram_boundary_scan_tap_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sram_boundary_scan_tap_tb;
	localparam int N = bst_pkg::BSR_LENGTH;
	localparam logic [127:0] P = {4{32'hC3A5_5A3C}};
	logic clk, rst, tck, tms, tmsDriven, tdi, tdiDriven, tdo, tdoOe, pinOverride, outBusOe, outBusFloat;
	logic [N-1:0] pinRing, pinDrive, q;
	logic [127:0] got;
	logic [2:0]   codes [4] = '{3'h7, 3'h7, 3'h7, 3'h7};
	logic         cell47 = 1'b1;
	int err_count = 0;
	int samples_checked = 0;
	bst_tap uut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tmsDriven(tmsDriven), .tdi(tdi),
		.tdiDriven(tdiDriven), .pinRing(pinRing), .tdo(tdo), .tdoOe(tdoOe), .pinDrive(pinDrive),
		.pinOverride(pinOverride), .outBusOe(outBusOe), .outBusFloat(outBusFloat));
	bst_ctl_model ctl (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tmsDriven(tmsDriven), .tdi(tdi),
		.tdiDriven(tdiDriven));
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_idcode();
		ctl.scan(1'b0, 32, '0, got);
		check("id", got, bst_pkg::ID_CODE_DEFAULT);
		check("idle oe", tdoOe, 1'b0);
		$display("idcode done");
	endtask
	task automatic t_bypass();
		foreach (codes[i]) begin
			ctl.scan(1'b1, 3, 128'(codes[i]), got);
			check("ir cap", got[1:0], bst_pkg::IR_CAPTURE);
			ctl.scan(1'b0, 8, 128'hA5, got);
			check("bypass", got, 128'h4A);
		end
		$display("bypass done");
	endtask
	task automatic t_scan(input logic [2:0] ins, input logic b47);
		q = ~P[N-1:0];
		q[47] = b47;
		ctl.scan(1'b1, 3, 128'(ins), got);
		check("float", outBusFloat, ins == bst_pkg::INS_SAMPLEZ || (ins == bst_pkg::INS_EXTEST && !cell47));
		ctl.scan(1'b0, N, 128'(q), got);
		cell47 = b47;
		check("ring", got, 128'(P[N-1:0]));
		check("latch", pinDrive, q);
		check("override", pinOverride, ins == bst_pkg::INS_EXTEST);
		check("bus oe", outBusOe, ins == bst_pkg::INS_EXTEST && b47);
		$display("scan %0d done", ins);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		stop_test();
	end
	initial begin
		rst = 1'b1;
		pinRing = P[N-1:0];
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check("reset oe", tdoOe, 1'b0);
		ctl.walk(8'h00, 1);
		t_idcode();
		t_bypass();
		t_scan(bst_pkg::INS_SAMPLE, 1'b0);
		t_scan(bst_pkg::INS_EXTEST, 1'b1);
		t_scan(bst_pkg::INS_EXTEST, 1'b0);
		t_scan(bst_pkg::INS_SAMPLEZ, 1'b0);
		ctl.reset5();
		cell47 = 1'b1;
		check("reset cell", pinDrive[47], 1'b1);
		check("reset float", outBusFloat, 1'b0);
		t_idcode();
		stop_test();
	end
endmodule // sram_boundary_scan_tap_tb
`default_nettype wire
